// File: hdl/pio_block.sv
// Top of the parallel I/O port block: APB slave and seven ports
`timescale 1ns/1ps
`default_nettype none
module pio_block import pio_pkg::*; #(
  parameter pio_word_t [PIO_NPORT-1:0] SHARED_MASK = {PIO_NPORT{16'hFFFF}}
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [PIO_AW-1:0] PADDR,
  input wire logic [PIO_DW-1:0] PWDATA,
  output logic [PIO_DW-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Pads
  input wire pio_word_t [PIO_NPORT-1:0] PAD_IN,
  output pio_word_t [PIO_NPORT-1:0] PAD_OUT,
  output pio_word_t [PIO_NPORT-1:0] PAD_OE,
  // Peripherals sharing the pads
  input wire pio_word_t [PIO_NPORT-1:0] PERIPH_EN,
  input wire pio_word_t [PIO_NPORT-1:0] PERIPH_DRV,
  input wire pio_word_t [PIO_NPORT-1:0] PERIPH_DAT
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [PIO_DW-1:0] prdata;
    pio_word_t ana;
    logic boot;
  } pio_top_st_t;

  localparam pio_top_st_t RST = '{pready: 1'b0, pslverr: 1'b0, prdata: '0, ana: PIO_ANA_RST, boot: 1'b1};
  localparam pio_word_t ANA_IMPL = PIO_IMPL[PIO_ANALOG_PORT];

  pio_top_st_t q;
  pio_top_st_t d;

  pio_word_t [PIO_NPORT-1:0] pin_smp;
  pio_word_t [PIO_NPORT-1:0] dir_w;
  pio_word_t [PIO_NPORT-1:0] lat_w;
  pio_word_t [PIO_NPORT-1:0] pin_w;
  logic [PIO_NPORT-1:0] wr_dir;
  logic [PIO_NPORT-1:0] wr_lat;
  pio_dec_t dec;
  logic acc;
  logic done;
  pio_word_t rd_val;

  // Pad levels are sampled once, so a read sees a pin change one cycle later
  pio_sample #(
    .W(PIO_NPORT * PIO_W)
  ) u_sample (
    .clk(MCLK),
    .rst_n(RST_N),
    .d_in(PAD_IN),
    .q_out(pin_smp)
  );

  genvar gp;
  generate
    for (gp = 0; gp < PIO_NPORT; gp++) begin : g_port
      pio_port #(
        .IMPL(PIO_IMPL[gp]),
        .SHARED(SHARED_MASK[gp]),
        .ANALOG(gp == PIO_ANALOG_PORT)
      ) u_port (
        .clk(MCLK),
        .rst_n(RST_N),
        .wr_dir(wr_dir[gp]),
        .wr_lat(wr_lat[gp]),
        .wdata(PWDATA[PIO_W-1:0]),
        .analog_cfg(q.ana),
        .pin_in(pin_smp[gp]),
        .periph_en(PERIPH_EN[gp]),
        .periph_drv(PERIPH_DRV[gp]),
        .periph_dat(PERIPH_DAT[gp]),
        .dir_q(dir_w[gp]),
        .lat_q(lat_w[gp]),
        .pin_rd(pin_w[gp]),
        .pad_out(PAD_OUT[gp]),
        .pad_oe(PAD_OE[gp])
      );
      // A pin state write lands in the latch, not on the pins
      assign wr_dir[gp] = done && PWRITE && dec.hit && dec.port == 3'(gp) && dec.kind == PIO_K_DIR;
      assign wr_lat[gp] = done && PWRITE && dec.hit && dec.port == 3'(gp)
                          && (dec.kind == PIO_K_LAT || dec.kind == PIO_K_PIN);
    end
  endgenerate

  // APB handshake: one wait state so read data can be registered
  assign dec = pio_decode(PADDR[PIO_AW-1:2]);
  assign acc = PSEL && PENABLE;
  assign done = acc && q.pready;

  always_comb begin
    rd_val = '0;
    if (dec.hit) begin
      unique case (dec.kind)
        PIO_K_DIR: rd_val = dir_w[dec.port];
        PIO_K_PIN: rd_val = pin_w[dec.port];
        PIO_K_LAT: rd_val = lat_w[dec.port];
        PIO_K_ANA: rd_val = q.ana;
      endcase
    end
  end

  always_comb begin
    d = q;
    d.boot = 1'b0;
    d.pready = acc && !q.pready;
    d.pslverr = acc && !q.pready && !dec.hit;
    // Upper half and missing pins stay zero on every read
    if (acc && !q.pready && !PWRITE) d.prdata = PIO_DW'(rd_val);
    if (done && PWRITE && dec.hit && dec.kind == PIO_K_ANA) d.ana = PWDATA[PIO_W-1:0] & ANA_IMPL;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign PRDATA = q.prdata;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_wr_b_lat;
    PSEL && PENABLE && PREADY && PWRITE && PADDR[PIO_AW-1:2] == PIO_IDX_LAT[1];
  endsequence

  sequence s_wr_b_pin;
    PSEL && PENABLE && PREADY && PWRITE && PADDR[PIO_AW-1:2] == PIO_IDX_PIN[1];
  endsequence

  sequence s_rd_b_pin;
    PSEL && !PENABLE && !PWRITE && PADDR[PIO_AW-1:2] == PIO_IDX_PIN[1]
    ##1 PSEL && PENABLE && !PREADY
    ##1 PREADY;
  endsequence

  sequence s_rd_b_lat;
    PSEL && !PENABLE && !PWRITE && PADDR[PIO_AW-1:2] == PIO_IDX_LAT[1]
    ##1 PSEL && PENABLE && !PREADY
    ##1 PREADY;
  endsequence

  sequence s_own_b0;
    PERIPH_EN[1][0] && PERIPH_DRV[1][0] && SHARED_MASK[1][0];
  endsequence

  sequence s_idle_b0;
    PERIPH_EN[1][0] && !PERIPH_DRV[1][0];
  endsequence

  AST_RESET_DIR: assert property (q.boot |-> dir_w == PIO_IMPL)
    else $error("direction not all inputs after reset");

  AST_LAT_WRITE: assert property (s_wr_b_lat |=> lat_w[1] == $past(PWDATA[PIO_W-1:0]))
    else $error("latch write not stored");

  AST_LAT_READ: assert property (s_rd_b_lat |-> PRDATA == PIO_DW'($past(lat_w[1])))
    else $error("latch read does not return latch");

  AST_PIN_WRITE: assert property (s_wr_b_pin |=> lat_w[1] == $past(PWDATA[PIO_W-1:0]))
    else $error("pin state write did not load latch");

  AST_PIN_READ: assert property (s_rd_b_pin |-> PRDATA[PIO_W-1:0] == ($past(pin_smp[1], 1) & ~$past(q.ana)))
    else $error("pin state read wrong");

  AST_ANALOG_ZERO: assert property (s_rd_b_pin |-> (PRDATA[PIO_W-1:0] & $past(q.ana)) == '0)
    else $error("analog pin read nonzero");

  AST_UNIMPL_ZERO: assert property (dir_w[0] == '0 && lat_w[0] == '0 && pin_w[0] == '0
                                    && (dir_w[2] & ~PIO_IMPL[2]) == '0)
    else $error("unimplemented bit nonzero");

  AST_UPPER_ZERO: assert property (PREADY |-> PRDATA[PIO_DW-1:PIO_W] == '0)
    else $error("reserved read bits nonzero");

  AST_PERIPH_OWN: assert property (s_own_b0 |=> PAD_OE[1][0] && PAD_OUT[1][0] == $past(PERIPH_DAT[1][0]))
    else $error("peripheral did not own pad");

  AST_PORT_DRIVE: assert property (s_idle_b0 ##1 s_idle_b0 |->
                                   PAD_OE[1][0] == !$past(dir_w[1][0]) && PAD_OUT[1][0] == $past(lat_w[1][0]))
    else $error("idle peripheral blocked port");

  AST_DIR_INPUT: assert property (!PERIPH_EN[3][0] && dir_w[3][0] |=> !PAD_OE[3][0])
    else $error("input pin drives pad");

  AST_UNMAPPED: assert property (PSEL && !PENABLE && !dec.hit ##1 PSEL && PENABLE |=> PSLVERR && PREADY)
    else $error("unmapped access not flagged");

endmodule : pio_block
`default_nettype wire

// File: hdl/pio_pkg.sv
// Package: register map, pin masks and decode for the parallel I/O port block
//
// How it works
// - A pin that an enabled peripheral is actively driving is driven by that peripheral, and the pin can still be read.
// - A pin whose peripheral is enabled but idle stays under control of the port logic.
// - A direction bit of one makes the pin an input; zero makes it an output driven from the latch.
// - Reset sets the direction bit of every implemented pin, so every pin starts as an input.
// - Reading the output latch register returns the latch, and writing it loads the latch.
// - Reading the pin state register returns the pin levels, and writing it loads the output latch.
// - Bits that a port does not have are disabled, and their latch, direction and pin reads give zero.
// - A pin shared only with an input-only function is a plain port pin with no output takeover.
// - On a shared pin, pad data and pad enable are each chosen between peripheral and port by a multiplexer.
// - Pins set up as analog inputs read as zero in the pin state register.
// - Unimplemented register bits always read as zero.
package pio_pkg;

  localparam int PIO_NPORT = 7;
  localparam int PIO_W = 16;
  localparam int PIO_DW = 32;
  localparam int PIO_IDX_W = 10;
  localparam int PIO_AW = PIO_IDX_W + 2;

  typedef logic [PIO_W-1:0] pio_word_t;
  typedef logic [PIO_IDX_W-1:0] pio_idx_t;

  // Register kinds within a port
  localparam logic [1:0] PIO_K_DIR = 2'h0;
  localparam logic [1:0] PIO_K_PIN = 2'h1;
  localparam logic [1:0] PIO_K_LAT = 2'h2;
  localparam logic [1:0] PIO_K_ANA = 2'h3;

  // Printed offsets are register indices; the byte address is four times the index
  localparam pio_idx_t [PIO_NPORT-1:0] PIO_IDX_DIR = {
    10'h2E4, 10'h2EE, 10'h2D8, 10'h2D2, 10'h2CC, 10'h2C6, 10'h2C0};
  localparam pio_idx_t [PIO_NPORT-1:0] PIO_IDX_PIN = {
    10'h2E6, 10'h2E0, 10'h2DA, 10'h2D4, 10'h2CE, 10'h2C8, 10'h2C2};
  localparam pio_idx_t [PIO_NPORT-1:0] PIO_IDX_LAT = {
    10'h2E8, 10'h2E2, 10'h2DC, 10'h2D6, 10'h2D0, 10'h2CB, 10'h2C4};
  localparam pio_idx_t PIO_IDX_ANA = 10'h2F0;

  // Implemented pins per port (G down to A); also the direction reset value
  localparam pio_word_t [PIO_NPORT-1:0] PIO_IMPL = {
    16'h03CC, 16'h007F, 16'h00FF, 16'h0FFF, 16'hE000, 16'hFFFF, 16'h0000};
  localparam pio_word_t PIO_LAT_RST = 16'h0000;
  localparam pio_word_t PIO_ANA_RST = 16'h0000;
  localparam int PIO_ANALOG_PORT = 1;

  typedef struct packed {
    logic hit;
    logic [1:0] kind;
    logic [2:0] port;
  } pio_dec_t;

  function automatic pio_dec_t pio_decode(input pio_idx_t idx);
    pio_dec_t r;
    r = '0;
    for (int p = 0; p < PIO_NPORT; p++) begin
      if (idx == PIO_IDX_DIR[p]) r = '{1'b1, PIO_K_DIR, 3'(p)};
      if (idx == PIO_IDX_PIN[p]) r = '{1'b1, PIO_K_PIN, 3'(p)};
      if (idx == PIO_IDX_LAT[p]) r = '{1'b1, PIO_K_LAT, 3'(p)};
    end
    if (idx == PIO_IDX_ANA) r = '{1'b1, PIO_K_ANA, 3'(PIO_ANALOG_PORT)};
    return r;
  endfunction : pio_decode

endpackage : pio_pkg

// File: hdl/pio_sample.sv
// Sampling register that takes the pad levels into the clock domain
`timescale 1ns/1ps
`default_nettype none
module pio_sample #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] smp;
  } pio_smp_st_t;

  pio_smp_st_t q;
  pio_smp_st_t d;

  always_comb begin
    d = q;
    d.smp = d_in;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_out = q.smp;

endmodule : pio_sample
`default_nettype wire

// File: hdl/pio_port.sv
// One 16-bit port: direction, latch, pad multiplexers and pin read path
`timescale 1ns/1ps
`default_nettype none
module pio_port import pio_pkg::*; #(
  parameter pio_word_t IMPL = '0,
  parameter pio_word_t SHARED = '0,
  parameter bit ANALOG = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register writes
  input wire logic wr_dir,
  input wire logic wr_lat,
  input wire pio_word_t wdata,
  input wire pio_word_t analog_cfg,
  // Pins and peripheral
  input wire pio_word_t pin_in,
  input wire pio_word_t periph_en,
  input wire pio_word_t periph_drv,
  input wire pio_word_t periph_dat,
  // State
  output pio_word_t dir_q,
  output pio_word_t lat_q,
  output pio_word_t pin_rd,
  output pio_word_t pad_out,
  output pio_word_t pad_oe
);

  typedef struct packed {
    pio_word_t dir;
    pio_word_t lat;
    pio_word_t out;
    pio_word_t oe;
  } pio_port_st_t;

  localparam pio_port_st_t RST = '{dir: IMPL, lat: PIO_LAT_RST, out: '0, oe: '0};
  localparam pio_word_t ANA_MASK = ANALOG ? IMPL : '0;

  pio_port_st_t q;
  pio_port_st_t d;
  pio_word_t own;

  always_comb begin
    // Input-only sharing leaves SHARED clear, so no takeover there
    own = periph_en & periph_drv & SHARED & IMPL;
    d = q;
    if (wr_dir) d.dir = wdata & IMPL;
    if (wr_lat) d.lat = wdata & IMPL;
    d.out = (own & periph_dat) | (~own & q.lat & IMPL);
    d.oe = own | (~own & ~q.dir & IMPL);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // Pin still readable while a peripheral owns it
  assign pin_rd = pin_in & IMPL & ~(analog_cfg & ANA_MASK);
  assign dir_q = q.dir;
  assign lat_q = q.lat;
  assign pad_out = q.out;
  assign pad_oe = q.oe;

endmodule : pio_port
`default_nettype wire

// File: testbench/pio_pin_model.sv
// Model of the external circuitry that sits on the I/O pads
`timescale 1ns/1ps
`default_nettype none
module pio_pin_model import pio_pkg::*; (
  // From the block
  input wire pio_word_t [PIO_NPORT-1:0] pad_out,
  input wire pio_word_t [PIO_NPORT-1:0] pad_oe,
  // Level that the outside world forces on undriven pads
  input wire pio_word_t [PIO_NPORT-1:0] ext_lvl,
  // Back to the block
  output pio_word_t [PIO_NPORT-1:0] pad_in
);
  // A driven pad shows what the block drives, so the port can read back its own outputs
  for (genvar p = 0; p < PIO_NPORT; p++) begin : g_pad
    assign pad_in[p] = (pad_oe[p] & pad_out[p]) | (~pad_oe[p] & ext_lvl[p]);
  end
endmodule : pio_pin_model
`default_nettype wire

// File: testbench/tb_pio_block.sv
// Testbench: register, pad and peripheral takeover checks for the I/O port block
`timescale 1ns/1ps
`default_nettype none
module tb_pio_block import pio_pkg::*; ;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [PIO_AW-1:0] paddr;
  logic [PIO_DW-1:0] pwdata, prdata, rd;
  pio_word_t [PIO_NPORT-1:0] pad_in, pad_out, pad_oe, ext, pen, pdrv, pdat;
  int n_mismatch, checks;
  // Port E bit 0 has an input-only sharer
  localparam pio_word_t [PIO_NPORT-1:0] SH = {16'hFFFF, 16'hFFFF, 16'hFFFE, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};

  pio_block #(.SHARED_MASK(SH)) uut (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PAD_IN(pad_in),
    .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PERIPH_EN(pen), .PERIPH_DRV(pdrv), .PERIPH_DAT(pdat));
  pio_pin_model pins (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext), .pad_in(pad_in));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Request stands until the rising edge at which ready is seen high
  task automatic apb(input logic wr, input pio_idx_t idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (n == 20) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input pio_idx_t idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input string nm, input pio_idx_t idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, exp, rd);
  endtask : rdc

  task automatic report_and_stop;
    $display("TB: checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext, pen, pdrv, pdat} = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    chk("oe_rst", 32'h0, {31'h0, |pad_oe});
    for (int p = 0; p < PIO_NPORT; p++) begin
      rdc("dir_rst", PIO_IDX_DIR[p], {16'h0000, PIO_IMPL[p]});
      rdc("lat_rst", PIO_IDX_LAT[p], 32'h0);
    end
    wr(PIO_IDX_LAT[1], 32'h1234);
    rdc("lat_b", PIO_IDX_LAT[1], 32'h1234);
    ext[1] <= 16'h0F0F;
    wr(PIO_IDX_PIN[1], 32'hFFFFA5A5);
    rdc("lat_b2", PIO_IDX_LAT[1], 32'hA5A5);
    rdc("pin_b", PIO_IDX_PIN[1], 32'h0F0F);
    wr(PIO_IDX_DIR[1], 32'hFF00);
    @(posedge mclk);
    rdc("pin_b_out", PIO_IDX_PIN[1], 32'h0FA5);
    chk("oe_b", 32'h00FF, {16'h0, pad_oe[1]});
    chk("out_b", 32'hA5A5, {16'h0, pad_out[1]});
    wr(PIO_IDX_ANA, 32'h0F00);
    rdc("ana", PIO_IDX_ANA, 32'h0F00);
    rdc("pin_b_ana", PIO_IDX_PIN[1], 32'h00A5);
    wr(PIO_IDX_LAT[2], 32'hFFFF);
    rdc("lat_c", PIO_IDX_LAT[2], 32'hE000);
    wr(PIO_IDX_DIR[2], 32'h0);
    repeat (3) @(posedge mclk);
    chk("oe_c", 32'hE000, {16'h0, pad_oe[2]});
    ext[0] <= 16'hFFFF;
    wr(PIO_IDX_LAT[0], 32'hFFFF);
    rdc("lat_a", PIO_IDX_LAT[0], 32'h0);
    rdc("pin_a", PIO_IDX_PIN[0], 32'h0);
    wr(PIO_IDX_LAT[3], 32'h0002);
    pen[3] <= 16'h0003;
    pdrv[3] <= 16'h0001;
    pdat[3] <= 16'h0001;
    pen[4] <= 16'h0001;
    pdrv[4] <= 16'h0001;
    pdat[4] <= 16'h0001;
    repeat (3) @(posedge mclk);
    chk("oe_d", 32'h0001, {16'h0, pad_oe[3]});
    chk("out_d", 32'h0003, {16'h0, pad_out[3]});
    chk("oe_e", 32'h0000, {16'h0, pad_oe[4]});
    rdc("pin_d", PIO_IDX_PIN[3], 32'h0001);
    wr(PIO_IDX_DIR[3], 32'h0FFD);
    repeat (3) @(posedge mclk);
    chk("oe_d2", 32'h0003, {16'h0, pad_oe[3]});
    chk("out_d2", 32'h0003, {16'h0, pad_out[3]});
    pen[1] <= 16'h0003;
    pdrv[1] <= 16'h0001;
    pdat[1] <= 16'h0000;
    repeat (3) @(posedge mclk);
    chk("out_b_own", 32'hA5A4, {16'h0, pad_out[1]});
    chk("oe_b_own", 32'h00FF, {16'h0, pad_oe[1]});
    pdrv[1] <= 16'h0000;
    repeat (3) @(posedge mclk);
    chk("out_b_idle", 32'hA5A5, {16'h0, pad_out[1]});
    apb(1'b1, 10'h3FF, 32'h1);
    chk("slverr", 32'h1, {31'h0, err});
    rdc("unmapped", 10'h3FF, 32'h0);
    report_and_stop();
  end
endmodule : tb_pio_block
`default_nettype wire
